// ### tsp_pkg.sv
// Shared constants, ptr table and timing for the touch sensor serial port.
package tsp_pkg;
    // Slave addresses chosen by the address select input.
    localparam logic [6:0] ADDR_LOW = 7'h4c;
    localparam logic [6:0] ADDR_HIGH = 7'h4d;
    // Register file size and the addresses with special behaviour.
    localparam int NUM_REGS = 12;
    localparam logic [7:0] REG_FIFO = 8'h00;
    localparam logic [7:0] REG_FAULT = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_CFG = 8'h0a;
    // Bit positions inside the configuration register.
    localparam int CFG_COMMS_POS = 0;
    localparam int CFG_RST_POS = 1;
    // Power-up values: reset bit idle high, comms disabled.
    localparam logic [7:0] CFG_RESET = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Clock and serial clock timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 400;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // Event buffer shape.
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // Next pointer value after a byte is written or read at p.
    function automatic logic [7:0] tsp_next_ptr(input logic [7:0] p);
        case (p)
            8'h01: tsp_next_ptr = 8'h02;
            8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09: tsp_next_ptr = p + 8'h01;
            8'h0b: tsp_next_ptr = 8'h0b;
            default: tsp_next_ptr = 8'h00;
        endcase
    endfunction
endpackage

// ### tsp_if.sv
// Two-wire bus, interrupt and attention lines joining host and device.
`timescale 1ns/1ps
interface tsp_if;
    logic m_scl_oe; // Host pulls the clock line low.
    logic m_sda_oe; // Host pulls the data line low.
    logic s_sda_oe; // Device pulls the data line low.
    logic s_irq_oe; // Device pulls the interrupt line low.
    logic attention_n; // Attention line, driven by the host.
    logic scl; // Resolved clock line level.
    logic sda; // Resolved data line level.
    logic irq_n; // Resolved interrupt line level.

    // Open-drain wires with pull-ups: low while anybody pulls.
    assign scl = ~m_scl_oe;
    assign sda = ~(m_sda_oe | s_sda_oe);
    assign irq_n = ~s_irq_oe;

    modport dev(input scl, input sda, input attention_n, output s_sda_oe, output s_irq_oe);
    modport host(input sda, input irq_n, output m_scl_oe, output m_sda_oe, output attention_n);
endinterface

// ### tsp_dev_port.sv
// Device end of the serial port, with its event FIFO.
`timescale 1ns/1ps
module tsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // The pointers wrap naturally only for a power of two depth.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("tsp_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words.
    logic [AW-1:0] wr_r; // Write index.
    logic [AW-1:0] rd_r; // Read index.
    logic [AW:0] cnt_r; // Words held.
    logic push;
    logic pop;

    assign in_ready = cnt_r != (AW + 1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rd_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Store the word being pushed.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Move the indices and the fill count.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_r + AW'(push);
            rd_r <= rd_r + AW'(pop);
            cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

module tsp_dev_port #(
    parameter int DEPTH = tsp_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    tsp_if.dev bus,
    input wire logic address_select,
    input wire logic event_valid,
    output logic event_ready,
    input wire logic [tsp_pkg::FIFO_WIDTH-1:0] event_data,
    input wire logic [7:0] fault_in,
    input wire logic [7:0] status_in,
    output logic comms_enable_bit,
    output logic [8*tsp_pkg::NUM_REGS-1:0] reg_image
);
    import tsp_pkg::*;

    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_CMD, D_WDATA, D_RDATA} tsp_dstate_t;

    logic [2:0] scl_q; // Clock line synchroniser plus one stage of history.
    logic [2:0] sda_q; // Data line synchroniser plus one stage of history.
    logic [1:0] attention_n_q; // Attention input synchroniser.
    logic [1:0] sel_q; // Address select synchroniser.
    logic [7:0] regs_r [NUM_REGS]; // Register file.
    tsp_dstate_t state_r; // Transfer state.
    logic [3:0] bit_r; // Clock rises seen in the current byte.
    logic [7:0] shift_r; // Received byte.
    logic [7:0] tx_r; // Bits still to send, msb next.
    logic [7:0] ptr_r; // Register pointer, loaded from the command byte and stepped after each data byte.
    logic rw_r; // Direction bit of the current address.
    logic mack_r; // Master acknowledged the last byte sent.
    logic sda_oe_r; // Pull data line low.
    logic scl_hi, scl_rise, scl_fall, start_ev, stop_ev;
    logic soft_rst, addr_hit, byte_done, ack_end, load, wr_strobe;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;
    logic fifo_valid;
    logic [FIFO_WIDTH-1:0] fifo_data;

    // Two flops on every pin before any logic reads it.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            attention_n_q <= 2'h3;
            sel_q <= 2'h0;
        end else begin
            scl_q <= {scl_q[1:0], bus.scl};
            sda_q <= {sda_q[1:0], bus.sda};
            attention_n_q <= {attention_n_q[0], bus.attention_n};
            sel_q <= {sel_q[0], address_select};
        end
    end

    // Bus conditions from the synchronised levels.
    assign scl_hi = scl_q[1] & scl_q[2];
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_ev = scl_hi & sda_q[2] & ~sda_q[1];
    assign stop_ev = scl_hi & ~sda_q[2] & sda_q[1];

    // A cleared reset bit acts for one cycle, then restores itself.
    assign soft_rst = ~regs_r[REG_CFG[3:0]][CFG_RST_POS];
    assign comms_enable_bit = regs_r[REG_CFG[3:0]][CFG_COMMS_POS];
    assign own_addr = sel_q[1] ? ADDR_HIGH : ADDR_LOW;
    assign addr_hit = (shift_r[7:1] == own_addr) & comms_enable_bit;
    assign byte_done = scl_fall & (bit_r == 4'd8);
    assign ack_end = scl_fall & (bit_r == 4'd9);
    assign wr_strobe = byte_done & (state_r == D_WDATA);
    // Fetch a byte after the address ack of a read or a master ack.
    assign load = ack_end & (((state_r == D_ADDR) & rw_r) | ((state_r == D_RDATA) & mack_r));

    // Value presented for the register under the pointer.
    always_comb begin
        if (ptr_r == REG_FIFO) begin
            rd_byte = fifo_valid ? fifo_data : 8'h00;
        end else if (ptr_r == REG_FAULT) begin
            rd_byte = fault_in;
        end else if (ptr_r == REG_STATUS) begin
            rd_byte = status_in;
        end else if (ptr_r < NUM_REGS) begin
            rd_byte = regs_r[ptr_r[3:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Byte engine: start, address, command, data and acknowledge slots.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || soft_rst) begin
            state_r <= D_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start_ev) begin
            // A start or repeated start always restarts addressing.
            state_r <= D_ADDR;
            bit_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_ev) begin
            // Stop frees the bus; the pointer is kept as it stands.
            state_r <= D_IDLE;
            sda_oe_r <= 1'b0;
        end else if (state_r != D_IDLE) begin
            if (scl_rise) begin
                // Sample on the rising edge; data is stable while high.
                if (bit_r < 4'd8) begin
                    shift_r <= {shift_r[6:0], sda_q[1]};
                end else begin
                    mack_r <= ~sda_q[1];
                end
                bit_r <= bit_r + 4'h1;
            end
            if (byte_done) begin
                // Eight bits in: acknowledge what we receive.
                case (state_r)
                    D_ADDR: begin
                        if (addr_hit) begin
                            rw_r <= shift_r[0];
                            sda_oe_r <= 1'b1;
                        end else begin
                            state_r <= D_IDLE;
                        end
                    end
                    D_CMD: begin
                        ptr_r <= shift_r;
                        sda_oe_r <= 1'b1;
                    end
                    D_WDATA: begin
                        ptr_r <= tsp_next_ptr(ptr_r);
                        sda_oe_r <= 1'b1;
                    end
                    default: begin
                        sda_oe_r <= 1'b0; // Master acknowledges our byte.
                    end
                endcase
            end else if (ack_end) begin
                // Acknowledge slot over: release and choose the next phase.
                bit_r <= 4'h0;
                sda_oe_r <= 1'b0;
                case (state_r)
                    D_ADDR: state_r <= rw_r ? D_RDATA : D_CMD;
                    D_CMD: state_r <= D_WDATA;
                    D_RDATA: begin
                        if (!mack_r) begin
                            state_r <= D_IDLE;
                        end
                    end
                    default: state_r <= state_r;
                endcase
                if (load) begin
                    // Drive the msb at once; the rest follows each fall.
                    sda_oe_r <= ~rd_byte[7];
                    tx_r <= {rd_byte[6:0], 1'b0};
                    ptr_r <= tsp_next_ptr(ptr_r);
                end
            end else if (scl_fall && state_r == D_RDATA) begin
                sda_oe_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // Register file: bus writes, attention and power-up values.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || soft_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= (i == int'(REG_CFG)) ? CFG_RESET : REG_RESET;
            end
        end else begin
            if (wr_strobe && ptr_r < NUM_REGS) begin
                regs_r[ptr_r[3:0]] <= shift_r;
            end
            // Attention wins over a write that clears the bit.
            if (!attention_n_q[1]) begin
                regs_r[REG_CFG[3:0]][CFG_COMMS_POS] <= 1'b1;
            end
        end
    end

    // Flatten the register file for the user side.
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            reg_image[8*i +: 8] = regs_r[i];
        end
    end

    // Events wait in the FIFO; reading the FIFO register pops one.
    tsp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(event_valid),
        .in_ready(event_ready),
        .in_data(event_data),
        .out_valid(fifo_valid),
        .out_ready(load && ptr_r == REG_FIFO),
        .out_data(fifo_data)
    );

    // Open-drain outputs: only enables leave the block.
    assign bus.s_sda_oe = sda_oe_r;
    assign bus.s_irq_oe = fifo_valid;
endmodule

// ### tsp_host_port.sv
// Host end: a bus master that sets the pointer, writes and reads.
`timescale 1ns/1ps
module tsp_host_port #(
    parameter int QUARTER = tsp_pkg::SCL_QUARTER_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    tsp_if.host bus,
    input wire logic [6:0] target_addr,
    input wire logic attention_req,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_ptr,
    input wire logic [3:0] cmd_len,
    input wire logic [7:0] wr_data,
    output logic wr_take,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic nack_seen,
    output logic irq_pending
);
    import tsp_pkg::*;

    // The device needs two quarters of low clock to answer a fall.
    if (QUARTER < 2 || QUARTER > 255) begin : g_bad_quarter
        $error("tsp_host_port quarter count must be 2 to 255");
    end

    typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} tsp_hstate_t;
    typedef enum logic [2:0] {P_ADDR_W, P_PTR, P_WDATA, P_ADDR_R, P_RDATA} tsp_hphase_t;

    tsp_hstate_t state_r; // Bus state.
    tsp_hphase_t phase_r; // Which byte is on the wire.
    logic [7:0] div_r; // Quarter period divider.
    logic [1:0] q_r; // Quarter within the bit.
    logic [1:0] sda_q; // Data line synchroniser.
    logic [1:0] irq_q; // Interrupt line synchroniser.
    logic [7:0] tx_r, rx_r, ptr_r;
    logic [3:0] bit_r, left_r;
    logic rd_r, scl_oe_r, sda_oe_r, tick;

    assign tick = (state_r != H_IDLE) && (div_r == 8'(QUARTER - 1));
    assign cmd_ready = state_r == H_IDLE;
    assign bus.m_scl_oe = scl_oe_r;
    assign bus.m_sda_oe = sda_oe_r;
    assign bus.attention_n = ~attention_req;
    assign irq_pending = irq_q[1];

    // Synchronise the returning data and interrupt lines.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sda_q <= 2'h3;
            irq_q <= 2'h0;
        end else begin
            sda_q <= {sda_q[0], bus.sda};
            irq_q <= {irq_q[0], ~bus.irq_n};
        end
    end

    // Quarter-period enable for the clock we generate.
    always_ff @(posedge sys_clk) begin
        if (!reset_n || state_r == H_IDLE || tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Master sequencer: start, bytes with acks, repeated start, stop.
    always_ff @(posedge sys_clk) begin
        wr_take <= 1'b0;
        rd_valid <= 1'b0;
        nack_seen <= 1'b0;
        if (!reset_n) begin
            state_r <= H_IDLE;
            phase_r <= P_ADDR_W;
            q_r <= 2'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            ptr_r <= 8'h00;
            bit_r <= 4'h0;
            left_r <= 4'h0;
            rd_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            rd_data <= 8'h00;
        end else if (state_r == H_IDLE) begin
            if (cmd_valid) begin
                state_r <= H_START;
                phase_r <= P_ADDR_W;
                q_r <= 2'h0;
                rd_r <= cmd_read;
                ptr_r <= cmd_ptr;
                left_r <= cmd_len;
            end
        end else if (tick) begin
            q_r <= q_r + 2'h1;
            case (state_r)
                H_START: begin
                    // Data falls while the clock is high.
                    case (q_r)
                        2'h0: sda_oe_r <= 1'b0;
                        2'h1: scl_oe_r <= 1'b0;
                        2'h2: sda_oe_r <= 1'b1;
                        default: begin
                            scl_oe_r <= 1'b1;
                            state_r <= H_BYTE;
                            bit_r <= 4'h0;
                            tx_r <= {target_addr, phase_r == P_ADDR_R};
                        end
                    endcase
                end
                H_BYTE: begin
                    case (q_r)
                        2'h0: begin
                            // Change data only while the clock is low.
                            if (bit_r < 4'd8) begin
                                sda_oe_r <= (phase_r != P_RDATA) & ~tx_r[7];
                            end else begin
                                sda_oe_r <= (phase_r == P_RDATA) & (left_r != 4'h1);
                            end
                        end
                        2'h2: scl_oe_r <= 1'b0;
                        2'h3: begin
                            scl_oe_r <= 1'b1;
                            if (bit_r < 4'd8) begin
                                rx_r <= {rx_r[6:0], sda_q[1]};
                                tx_r <= {tx_r[6:0], 1'b0};
                                bit_r <= bit_r + 4'h1;
                            end else begin
                                bit_r <= 4'h0;
                                case (phase_r)
                                    P_RDATA: begin
                                        rd_data <= rx_r;
                                        rd_valid <= 1'b1;
                                        left_r <= left_r - 4'h1;
                                        if (left_r == 4'h1) begin
                                            state_r <= H_STOP;
                                        end
                                    end
                                    default: begin
                                        if (sda_q[1]) begin
                                            nack_seen <= 1'b1;
                                            state_r <= H_STOP;
                                        end else if (phase_r == P_ADDR_W) begin
                                            phase_r <= P_PTR;
                                            tx_r <= ptr_r;
                                        end else if (phase_r == P_ADDR_R) begin
                                            phase_r <= P_RDATA;
                                        end else if (phase_r == P_PTR && rd_r && left_r != 4'h0) begin
                                            phase_r <= P_ADDR_R;
                                            state_r <= H_START;
                                        end else if (phase_r == P_PTR && !rd_r && left_r != 4'h0) begin
                                            phase_r <= P_WDATA;
                                            tx_r <= wr_data;
                                            wr_take <= 1'b1;
                                        end else if (phase_r == P_WDATA && left_r > 4'h1) begin
                                            left_r <= left_r - 4'h1;
                                            tx_r <= wr_data;
                                            wr_take <= 1'b1;
                                        end else begin
                                            state_r <= H_STOP;
                                        end
                                    end
                                endcase
                            end
                        end
                        default: scl_oe_r <= scl_oe_r;
                    endcase
                end
                H_STOP: begin
                    // Data rises while the clock is high.
                    case (q_r)
                        2'h0: sda_oe_r <= 1'b1;
                        2'h1: scl_oe_r <= 1'b0;
                        2'h2: sda_oe_r <= 1'b0;
                        default: state_r <= H_IDLE;
                    endcase
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end
endmodule

// ### tsp_assertions.sv
// Bus checks for the two-wire link between host and device ends.
`timescale 1ns/1ps
module tsp_assertions (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic m_scl_oe,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic s_irq_oe,
    input wire logic attention_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic irq_n
);
    // Every check runs on the system clock and rests while reset is low.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // The interrupt line is only released by a FIFO fetch, which falls in a low clock phase.
    irq_pull_a: assert property ($rose(irq_n) |-> !scl) else $error("irq released with scl high");
    // Both ends may pull data together only while the clock is low, never across a sample.
    sda_pull_a: assert property (s_sda_oe && m_sda_oe |-> !scl) else $error("both ends pull sda with scl high");
    dev_edge_a: assert property ($rose(s_sda_oe) |-> !scl) else $error("device pull with scl high");
    dev_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe)) else $error("device sda moved");
    // Stop and repeated start release the clock after two quarters, so four samples is the floor.
    scl_low_a: assert property ($fell(scl) |-> !scl [*4]) else $error("scl low too short");
    scl_high_a: assert property ($rose(scl) |-> scl [*2]) else $error("scl high too short");
    start_shape_a: assert property ($fell(sda) && scl |-> scl [*2] ##1 !scl) else $error("bad start");
    stop_idle_a: assert property ($rose(sda) && scl |-> (sda && scl) [*4]) else $error("bad stop");
    // Main traffic seen: starts, device acks and raised interrupts.
    cover property ($fell(sda) && scl && !m_scl_oe);
    cover property (s_sda_oe && $rose(scl) && !m_sda_oe);
    cover property ($fell(irq_n) && attention_n);
endmodule

// ### touch_sensor_i2c_slave_port_tb.sv
// Self-checking bench joining the host end to the device end.
`timescale 1ns/1ps
module touch_sensor_i2c_slave_port_tb;
    import tsp_pkg::*;
    logic sys_clk = 0, reset_n = 0, asel = 0, att = 0, cv = 0, crd = 0, ev_v = 0, ev_r, cr, wt, rv, nk, irq, ce;
    logic [6:0] tgt = ADDR_LOW;
    logic [7:0] cp = 0, wd = 0, ev_d = 0, fi = 0, si = 0, rdd, v;
    logic [3:0] cl = 0;
    logic [95:0] img;
    logic [7:0] wdat [4];
    logic [8:0] exp_q [$];
    logic [7:0] evq [$];
    logic [31:0] seed = 32'h14df;
    int failures = 0, n_tests = 0;
    tsp_if bus_if ();
    always #25 sys_clk = ~sys_clk;
    tsp_dev_port tsp_dev_port_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_if), .address_select(asel),
        .event_valid(ev_v), .event_ready(ev_r), .event_data(ev_d), .fault_in(fi), .status_in(si),
        .comms_enable_bit(ce), .reg_image(img));
    tsp_host_port tsp_host_port_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_if), .target_addr(tgt),
        .attention_req(att), .cmd_valid(cv), .cmd_ready(cr), .cmd_read(crd), .cmd_ptr(cp), .cmd_len(cl),
        .wr_data(wd), .wr_take(wt), .rd_valid(rv), .rd_data(rdd), .nack_seen(nk), .irq_pending(irq));
    tsp_assertions tsp_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n), .m_scl_oe(bus_if.m_scl_oe),
        .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe), .s_irq_oe(bus_if.s_irq_oe),
        .attention_n(bus_if.attention_n), .scl(bus_if.scl), .sda(bus_if.sda), .irq_n(bus_if.irq_n));
    // Xorshift source for all random stimulus.
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One host command; feeds write bytes on each take and waits, bounded, for idle.
    task automatic xfer(input logic rd, input logic [7:0] p, input logic [3:0] n);
        int k;
        int wi;
        wi = 0;
        crd <= rd;
        cp <= p;
        cl <= n;
        wd <= wdat[0];
        cv <= 1'b1;
        @(posedge sys_clk);
        cv <= 1'b0;
        for (k = 0; k < 3000 && (k < 2 || cr !== 1'b1); k++) begin
            @(posedge sys_clk);
            if (wt === 1'b1 && wi < 3) begin
                wi++;
                wd <= wdat[wi];
            end
        end
        if (k == 3000) begin
            failures++;
            wrap_up();
        end
    endtask
    // Each read byte or nack is matched against the oldest noted result.
    always @(posedge sys_clk) begin
        if (rv === 1'b1 || nk === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0 || exp_q[0] !== {nk, nk ? 8'h00 : rdd}) begin
                failures++;
                $display("wrong value read exp %h got %h", exp_q.size() ? exp_q[0] : 9'h0, {nk, rdd});
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        fi = xs();
        si = xs();
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("cfg", CFG_RESET, img[87:80]);
        exp_q.push_back(9'h100);
        xfer(1'b0, 8'h03, 4'h0);
        att <= 1'b1;
        repeat (4) @(posedge sys_clk);
        att <= 1'b0;
        chk("comms", 8'h01, {7'h0, ce});
        $display("test attention done");
        for (int i = 0; i < 2; i++) begin
            asel <= i[0];
            tgt <= i ? ADDR_LOW : ADDR_HIGH;
            exp_q.push_back(9'h100);
            xfer(1'b0, 8'h03, 4'h0);
            tgt <= i ? ADDR_HIGH : ADDR_LOW;
            foreach (wdat[j]) wdat[j] = xs();
            xfer(1'b0, 8'h03, 4'h3);
            for (int j = 0; j < 3; j++) chk("reg", wdat[j], img[8*(j+3) +: 8]);
            xfer(1'b0, 8'h04, 4'h0);
            chk("reg4", wdat[1], img[39:32]);
            for (int j = 0; j < 3; j++) exp_q.push_back({1'b0, wdat[j]});
            xfer(1'b1, 8'h03, 4'h3);
        end
        $display("test address and burst done");
        while (evq.size() < 20) begin
            v = xs();
            ev_d <= v;
            ev_v <= 1'b1;
            @(posedge sys_clk);
            if (ev_r !== 1'b1) break;
            evq.push_back(v);
        end
        ev_v <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("fill", 8'(FIFO_DEPTH), 8'(evq.size()));
        chk("irq", 8'h01, {7'h0, irq});
        exp_q.push_back({1'b0, fi});
        exp_q.push_back({1'b0, si});
        exp_q.push_back({1'b0, evq.pop_front()});
        xfer(1'b1, 8'h01, 4'h3);
        while (evq.size() > 0) exp_q.push_back({1'b0, evq.pop_front()});
        xfer(1'b1, 8'h00, 4'hf);
        repeat (4) @(posedge sys_clk);
        chk("irq", 8'h00, {7'h0, irq});
        exp_q.push_back(9'h000);
        exp_q.push_back({1'b0, CFG_RESET | 8'h01});
        exp_q.push_back(9'h000);
        xfer(1'b1, 8'h09, 4'h3);
        $display("test fifo done");
        wdat[0] = 8'h00;
        exp_q.push_back(9'h100);
        xfer(1'b0, REG_CFG, 4'h1);
        chk("cfg", CFG_RESET, img[87:80]);
        chk("reg3", REG_RESET, img[31:24]);
        chk("left", 8'h00, 8'(exp_q.size()));
        $display("test soft reset done");
        wrap_up();
    end
endmodule
